// ---- hw/sensor_id_status_registers.sv ----
// How it works
// - Part identifier fixed in ID bits 10-0
// - Die revision fixed in ID bits 15-11
// - Capability register reads fixed one
// - Device reset zeroes the status register
// - Function event sets sticky bit 0
// - Bit 0 cleared by reset or handling
// - Function error indication sets bit 4
// - Bit 4 cleared by reset or handling
// - Any no-acknowledge sets bit 7
// - Bit 7 cleared by reset or status read
// - Status bits 3-1, 6-5 read zero
// - Readout read clears event and error flags
// - Unread result overwritten sets error flag
// - Device reset returns all registers to default
`timescale 1ns/1ps
`default_nettype none
module sensor_id_status_registers (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          dev_reset_i,
  input  wire logic                          rd_en_i,
  input  wire sensor_regs_pkg::reg_addr_type rd_addr_i,
  input  wire logic                          func_event_i,
  input  wire logic                          func_error_i,
  input  wire logic                          ack_nak_i,
  output logic                               rd_valid_o,
  output sensor_regs_pkg::reg_data_type      rd_data_o,
  output logic                               function_event_flag_o,
  output logic                               function_error_flag_o,
  output logic                               bus_ack_error_flag_o
);
  import sensor_regs_pkg::*;

  status_if sif ();

  reg_data_type rd_data_reg;
  reg_data_type rd_data_next;
  logic         rd_valid_reg;
  logic         rd_valid_next;
  logic         rd_take;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic status_type status_word(input logic ev, input logic err,
                                             input logic nak);
    status_type s;
    s            = STATUS_RESET;
    s[EVENT_BIT] = ev;
    s[ERROR_BIT] = err;
    s[NAK_BIT]   = nak;
    return s;
  endfunction : status_word

  function automatic reg_data_type id_word();
    reg_data_type w;
    w                                = DATA_ZERO;
    w[PART_ID_LSB +: PART_ID_W]      = PART_ID_VALUE;
    w[REV_LSB +: REV_W]              = DIE_REVISION_VALUE;
    return w;
  endfunction : id_word

  // ----------------------------------------------------------------
  // Flag unit
  // ----------------------------------------------------------------
  // Reads during a device reset are dropped so they cannot clear flags
  assign rd_take          = rd_en_i & ~dev_reset_i;
  assign sif.func_event   = func_event_i;
  assign sif.func_error   = func_error_i;
  assign sif.ack_nak      = ack_nak_i;
  assign sif.soft_reset   = dev_reset_i;
  assign sif.status_read  = rd_take && (rd_addr_i == STATUS_ADDR);
  assign sif.readout_read = rd_take && (rd_addr_i == READOUT_ADDR);

  status_flags u_flags (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .sif     (sif)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // The status word is sampled from the flag registers before the
  // read-clear lands, so the reader always sees the ack error bit.
  always_comb begin
    rd_data_next  = DATA_ZERO;
    rd_valid_next = rd_take;
    if (rd_take) begin
      unique case (rd_addr_i)
        ID_ADDR:     rd_data_next = id_word();
        CAP_ADDR:    rd_data_next = CAP_VALUE;
        STATUS_ADDR: rd_data_next = {{(DATA_W-STATUS_W){1'b0}},
                                     status_word(sif.function_event_flag,
                                                 sif.function_error_flag,
                                                 sif.bus_ack_error_flag)};
        default:     rd_data_next = DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_reg  <= DATA_ZERO;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign rd_data_o             = rd_data_reg;
  assign rd_valid_o            = rd_valid_reg;
  assign function_event_flag_o = sif.function_event_flag;
  assign function_error_flag_o = sif.function_error_flag;
  assign bus_ack_error_flag_o  = sif.bus_ack_error_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_id_value;
    @(posedge clk_i) disable iff (!rst_n_i)
      rd_take && rd_addr_i == ID_ADDR |=>
        rd_valid_o && rd_data_o[PART_ID_LSB +: PART_ID_W] == PART_ID_VALUE;
  endproperty
  a_id_value: assert property (p_id_value)
    else $error("part identifier read back wrong");

  property p_rev_value;
    @(posedge clk_i) disable iff (!rst_n_i)
      rd_take && rd_addr_i == ID_ADDR |=> rd_data_o[REV_LSB +: REV_W] == DIE_REVISION_VALUE;
  endproperty
  a_rev_value: assert property (p_rev_value)
    else $error("die revision read back wrong");

  property p_cap_value;
    @(posedge clk_i) disable iff (!rst_n_i)
      rd_take && rd_addr_i == CAP_ADDR |=> rd_valid_o && rd_data_o == CAP_VALUE;
  endproperty
  a_cap_value: assert property (p_cap_value)
    else $error("capability register not one");

  property p_reserved_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
      rd_take && rd_addr_i == STATUS_ADDR |=>
        rd_data_o[DATA_W-1:NAK_BIT+1] == '0 && rd_data_o[NAK_BIT-1:ERROR_BIT+1] == '0
        && rd_data_o[ERROR_BIT-1:EVENT_BIT+1] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved status bits not zero");

  property p_status_pre_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
      rd_take && rd_addr_i == STATUS_ADDR && bus_ack_error_flag_o |=> rd_data_o[NAK_BIT];
  endproperty
  a_status_pre_clear: assert property (p_status_pre_clear)
    else $error("status read lost the ack error bit");

  property p_status_flags_match;
    @(posedge clk_i) disable iff (!rst_n_i)
      rd_take && rd_addr_i == STATUS_ADDR |=>
        rd_data_o[EVENT_BIT] == $past(function_event_flag_o)
        && rd_data_o[ERROR_BIT] == $past(function_error_flag_o);
  endproperty
  a_status_flags_match: assert property (p_status_flags_match)
    else $error("status read does not match flags");

  property p_dev_reset_defaults;
    @(posedge clk_i) disable iff (!rst_n_i)
      dev_reset_i |=> !rd_valid_o && rd_data_o == DATA_ZERO && !function_event_flag_o
        && !function_error_flag_o && !bus_ack_error_flag_o;
  endproperty
  a_dev_reset_defaults: assert property (p_dev_reset_defaults)
    else $error("device reset did not restore defaults");

  property p_status_nak_match;
    @(posedge clk_i) disable iff (!rst_n_i)
      rd_take && rd_addr_i == STATUS_ADDR |=>
        rd_data_o[NAK_BIT] == $past(bus_ack_error_flag_o);
  endproperty
  a_status_nak_match: assert property (p_status_nak_match)
    else $error("status read ack error bit differs from the flag");

  property p_status_read_clears_nak;
    @(posedge clk_i) disable iff (!rst_n_i)
      rd_take && rd_addr_i == STATUS_ADDR && !ack_nak_i |=> !bus_ack_error_flag_o;
  endproperty
  a_status_read_clears_nak: assert property (p_status_read_clears_nak)
    else $error("ack error output survived a status read");

  property p_readout_clears_outputs;
    @(posedge clk_i) disable iff (!rst_n_i)
      rd_take && rd_addr_i == READOUT_ADDR && !func_event_i && !func_error_i |=>
        !function_event_flag_o && !function_error_flag_o;
  endproperty
  a_readout_clears_outputs: assert property (p_readout_clears_outputs)
    else $error("readout read left event or error output set");

  property p_port_nak_sets;
    @(posedge clk_i) disable iff (!rst_n_i)
      ack_nak_i && !dev_reset_i |=> bus_ack_error_flag_o;
  endproperty
  a_port_nak_sets: assert property (p_port_nak_sets)
    else $error("ack error output not set after no-acknowledge");

  property p_dropped_read;
    @(posedge clk_i) disable iff (!rst_n_i)
      rd_en_i && dev_reset_i |=> !rd_valid_o;
  endproperty
  a_dropped_read: assert property (p_dropped_read)
    else $error("read answered during device reset");

  // A result overwritten before its readout read must raise the error output
  property p_port_overrun;
    @(posedge clk_i) disable iff (!rst_n_i)
      function_event_flag_o && func_event_i && !dev_reset_i
        && !(rd_take && rd_addr_i == READOUT_ADDR) |=> function_error_flag_o;
  endproperty
  a_port_overrun: assert property (p_port_overrun)
    else $error("overrun did not raise the error output");

endmodule : sensor_id_status_registers
`default_nettype wire

// ---- hw/sensor_regs_pkg.sv ----
package sensor_regs_pkg;

  // ----------------------------------------------------------------
  // Widths and types
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 6;
  localparam int DATA_W   = 16;
  localparam int STATUS_W = 8;

  typedef logic [ADDR_W-1:0]   reg_addr_type;
  typedef logic [DATA_W-1:0]   reg_data_type;
  typedef logic [STATUS_W-1:0] status_type;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam reg_addr_type ID_ADDR      = 6'h02;
  localparam reg_addr_type CAP_ADDR     = 6'h03;
  localparam reg_addr_type STATUS_ADDR  = 6'h04;
  localparam reg_addr_type READOUT_ADDR = 6'h09;

  // ----------------------------------------------------------------
  // Identification fields (values arbitrary, not a real part)
  // ----------------------------------------------------------------
  localparam int          PART_ID_W          = 11;
  localparam int          REV_W              = 5;
  localparam int          PART_ID_LSB        = 0;
  localparam int          REV_LSB            = 11;
  localparam logic [10:0] PART_ID_VALUE      = 11'h155;
  localparam logic [4:0]  DIE_REVISION_VALUE = 5'h01;

  // ----------------------------------------------------------------
  // Fixed values, reset values and status bit positions
  // ----------------------------------------------------------------
  localparam reg_data_type CAP_VALUE    = 16'h0001;
  localparam reg_data_type DATA_ZERO    = 16'h0000;
  localparam status_type   STATUS_RESET = 8'h00;
  localparam int           EVENT_BIT    = 0;
  localparam int           ERROR_BIT    = 4;
  localparam int           NAK_BIT      = 7;

endpackage : sensor_regs_pkg

// ---- hw/status_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface status_if;
  logic func_event;
  logic func_error;
  logic ack_nak;
  logic status_read;
  logic readout_read;
  logic soft_reset;
  logic function_event_flag;
  logic function_error_flag;
  logic bus_ack_error_flag;

  modport ctrl (
    output func_event, func_error, ack_nak, status_read, readout_read, soft_reset,
    input  function_event_flag, function_error_flag, bus_ack_error_flag
  );
  modport flags (
    input  func_event, func_error, ack_nak, status_read, readout_read, soft_reset,
    output function_event_flag, function_error_flag, bus_ack_error_flag
  );
endinterface : status_if
`default_nettype wire

// ---- hw/status_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
module status_flags (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  status_if.flags   sif
);
  import sensor_regs_pkg::*;

  logic ev_reg;
  logic ev_next;
  logic err_reg;
  logic err_next;
  logic nak_reg;
  logic nak_next;
  logic overrun;

  // ----------------------------------------------------------------
  // Next flag values; a set wins over a same-cycle read clear, device reset wins over both
  // ----------------------------------------------------------------
  always_comb begin
    // A new result while the old one is still unread is an overrun
    overrun = sif.func_event & ev_reg & ~sif.readout_read;
    ev_next  = ev_reg;
    err_next = err_reg;
    nak_next = nak_reg;
    if (sif.readout_read) begin
      ev_next  = 1'b0;
      err_next = 1'b0;
    end
    if (sif.status_read) begin
      nak_next = 1'b0;
    end
    if (sif.func_event) begin
      ev_next = 1'b1;
    end
    if (sif.func_error | overrun) begin
      err_next = 1'b1;
    end
    if (sif.ack_nak) begin
      nak_next = 1'b1;
    end
    // Device reset aborts everything, including a pending set
    if (sif.soft_reset) begin
      ev_next  = STATUS_RESET[EVENT_BIT];
      err_next = STATUS_RESET[ERROR_BIT];
      nak_next = STATUS_RESET[NAK_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ev_reg  <= STATUS_RESET[EVENT_BIT];
      err_reg <= STATUS_RESET[ERROR_BIT];
      nak_reg <= STATUS_RESET[NAK_BIT];
    end else begin
      ev_reg  <= ev_next;
      err_reg <= err_next;
      nak_reg <= nak_next;
    end
  end

  assign sif.function_event_flag = ev_reg;
  assign sif.function_error_flag = err_reg;
  assign sif.bus_ack_error_flag  = nak_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_event_sets;
    @(posedge clk_i) disable iff (!rst_n_i)
      sif.func_event && !sif.soft_reset |=> ev_reg;
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("event flag not set after function event");

  property p_event_holds;
    @(posedge clk_i) disable iff (!rst_n_i)
      ev_reg && !sif.readout_read && !sif.soft_reset |=> ev_reg;
  endproperty
  a_event_holds: assert property (p_event_holds)
    else $error("event flag dropped without a readout read or reset");

  property p_error_sets;
    @(posedge clk_i) disable iff (!rst_n_i)
      sif.func_error && !sif.soft_reset |=> err_reg;
  endproperty
  a_error_sets: assert property (p_error_sets)
    else $error("error flag not set after error indication");

  property p_error_holds;
    @(posedge clk_i) disable iff (!rst_n_i)
      err_reg && !sif.readout_read && !sif.soft_reset |=> err_reg;
  endproperty
  a_error_holds: assert property (p_error_holds)
    else $error("error flag dropped without a readout read or reset");

  property p_nak_sets;
    @(posedge clk_i) disable iff (!rst_n_i)
      sif.ack_nak && !sif.soft_reset |=> nak_reg;
  endproperty
  a_nak_sets: assert property (p_nak_sets)
    else $error("ack error flag not set after no-acknowledge");

  property p_status_read_clears;
    @(posedge clk_i) disable iff (!rst_n_i)
      sif.status_read && !sif.ack_nak ##1 !sif.ack_nak[*2] |-> !nak_reg;
  endproperty
  a_status_read_clears: assert property (p_status_read_clears)
    else $error("ack error flag survived a status read");

  property p_readout_clears;
    @(posedge clk_i) disable iff (!rst_n_i)
      sif.readout_read && !sif.func_event && !sif.func_error |=> !ev_reg && !err_reg;
  endproperty
  a_readout_clears: assert property (p_readout_clears)
    else $error("readout read did not clear event and error flags");

  property p_overrun;
    @(posedge clk_i) disable iff (!rst_n_i)
      ev_reg && sif.func_event && !sif.readout_read && !sif.soft_reset |=> err_reg && ev_reg;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun did not set the error flag");

  property p_reset_clears;
    @(posedge clk_i) disable iff (!rst_n_i)
      sif.soft_reset |=> !ev_reg && !err_reg && !nak_reg;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("device reset left a status flag set");

endmodule : status_flags
`default_nettype wire

// ---- sim/master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module master_model
  import sensor_regs_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         rd_valid_i,
  input  wire reg_data_type rd_data_i,
  output logic              rd_en_o,
  output reg_addr_type      rd_addr_o
);
  initial begin
    rd_en_o   = 1'b0;
    rd_addr_o = 6'h3F;
  end

  // One-cycle read strobe; gap cycles model a slow master. The answer
  // stands for the whole cycle after the taking edge, so it is sampled there.
  task automatic read(input int gap, input reg_addr_type addr,
                      output logic valid, output reg_data_type data);
    while (!rst_n_i) @(posedge clk_i);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    #1 rd_en_o = 1'b1;
    rd_addr_o = addr;
    @(posedge clk_i);
    #1 rd_en_o = 1'b0;
    rd_addr_o = 6'h3F;
    valid = rd_valid_i;
    data  = rd_data_i;
  endtask : read
endmodule : master_model
`default_nettype wire

// ---- sim/test_sensor_id_status_registers.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_sensor_id_status_registers;
  import sensor_regs_pkg::*;

  logic         clk_i;
  logic         rst_n_i;
  logic         dev_reset_i;
  logic         func_event_i;
  logic         func_error_i;
  logic         ack_nak_i;
  logic         rd_en_i;
  reg_addr_type rd_addr_i;
  logic         rd_valid_o;
  reg_data_type rd_data_o;
  logic         ev_flag;
  logic         er_flag;
  logic         nak_flag;
  int           num_errors;
  int           num_checks;
  int           cycles;

  sensor_id_status_registers sensor_id_status_registers_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .dev_reset_i(dev_reset_i),
    .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .func_event_i(func_event_i),
    .func_error_i(func_error_i), .ack_nak_i(ack_nak_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .function_event_flag_o(ev_flag), .function_error_flag_o(er_flag),
    .bus_ack_error_flag_o(nak_flag)
  );

  master_model master_model_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .rd_valid_i(rd_valid_o),
    .rd_data_i(rd_data_o), .rd_en_o(rd_en_i), .rd_addr_o(rd_addr_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  task automatic check(input string name, input reg_data_type seen, input reg_data_type exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic flags(input logic [2:0] exp);
    check("flags", {13'h0, nak_flag, er_flag, ev_flag}, {13'h0, exp});
  endtask : flags

  // Reads and checks both the valid strobe and the data word
  task automatic rd(input int gap, input reg_addr_type a, input reg_data_type exp);
    logic         v;
    reg_data_type d;
    master_model_i.read(gap, a, v, d);
    check("rd_valid", {15'h0, v}, 16'h0001);
    check("rd_data", d, exp);
  endtask : rd

  task automatic pulse(input logic ev, input logic er, input logic nk);
    @(posedge clk_i);
    #1 func_event_i = ev;
    func_error_i = er;
    ack_nak_i    = nk;
    @(posedge clk_i);
    #1 func_event_i = 1'b0;
    func_error_i = 1'b0;
    ack_nak_i    = 1'b0;
  endtask : pulse

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_fixed();
    rd(0, ID_ADDR, {DIE_REVISION_VALUE, PART_ID_VALUE});
    rd(0, CAP_ADDR, 16'h0001);
    rd(2, STATUS_ADDR, 16'h0000);
    rd(0, 6'h0B, 16'h0000);
  endtask : t_fixed

  task automatic t_event();
    pulse(1'b1, 1'b0, 1'b0);
    flags(3'b001);
    rd(0, STATUS_ADDR, 16'h0001);
    rd(3, CAP_ADDR, 16'h0001);
    flags(3'b001);
    rd(0, READOUT_ADDR, 16'h0000);
    flags(3'b000);
  endtask : t_event

  task automatic t_error();
    pulse(1'b0, 1'b1, 1'b0);
    flags(3'b010);
    rd(0, STATUS_ADDR, 16'h0010);
    flags(3'b010);
    rd(1, READOUT_ADDR, 16'h0000);
    flags(3'b000);
  endtask : t_error

  task automatic t_overrun();
    pulse(1'b1, 1'b0, 1'b0);
    pulse(1'b1, 1'b0, 1'b0);
    flags(3'b011);
    rd(0, READOUT_ADDR, 16'h0000);
    flags(3'b000);
  endtask : t_overrun

  task automatic t_nak();
    pulse(1'b1, 1'b1, 1'b1);
    flags(3'b111);
    rd(0, STATUS_ADDR, 16'h0091);
    flags(3'b011);
    rd(0, STATUS_ADDR, 16'h0011);
    rd(0, READOUT_ADDR, 16'h0000);
    flags(3'b000);
  endtask : t_nak

  // Read issued while device reset is high must be dropped
  task automatic t_dev_reset();
    logic         v;
    reg_data_type d;
    pulse(1'b1, 1'b1, 1'b1);
    @(posedge clk_i);
    #1 dev_reset_i = 1'b1;
    master_model_i.read(0, STATUS_ADDR, v, d);
    dev_reset_i = 1'b0;
    check("rd_valid", {15'h0, v}, 16'h0000);
    flags(3'b000);
    rd(0, STATUS_ADDR, 16'h0000);
    rd(0, ID_ADDR, {DIE_REVISION_VALUE, PART_ID_VALUE});
    pulse(1'b1, 1'b1, 1'b1);
    flags(3'b111);
    @(posedge clk_i);
    #1 rst_n_i = 1'b0;
    #1 flags(3'b000);
    @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    rd(0, STATUS_ADDR, 16'h0000);
  endtask : t_dev_reset

  // A hang is cut short well beyond the fewer than a hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles >= 2000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    num_errors   = 0;
    num_checks   = 0;
    cycles       = 0;
    rst_n_i      = 1'b0;
    dev_reset_i  = 1'b0;
    func_event_i = 1'b0;
    func_error_i = 1'b0;
    ack_nak_i    = 1'b0;
    repeat (6) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    t_fixed();
    t_event();
    t_error();
    t_overrun();
    t_nak();
    t_dev_reset();
    final_report();
  end
endmodule : test_sensor_id_status_registers
`default_nettype wire
